/* File: design/dcc_ctrl.sv */
// Command interpreter for spindle, cache flush, readiness and verify commands.
//
// Function
// - Start bit spins motor up, zero stops it.
// - Immed zero: status after motor operation finishes.
// - Immed one: GOOD status at once.
// - After first ready, start/stop always accepted.
// - Flush writes cached blocks from given address.
// - Zero block count flushes to unit end.
// - Flush status only after flush completes.
// - Flush immed bit set: illegal request, invalid field.
// - Flush relative bit set: illegal request, invalid field.
// - Readiness test reports not ready off speed.
// - At speed, media commands accepted as ready.
// - Readiness test runs no self diagnostic.
// - Spindle starts on its own at power-up.
// - Before power-on ends only three commands run.
// - Zero-length verify moves nothing, no error.
// - Byte-compare zero: ECC check, medium error.
// - Byte-compare one: compare data, miscompare error.
// - Disable-page-out one: lowest cache retention priority.
// - Disable-page-out zero: configured retention priority.
`timescale 1ns/1ps
`include "dcc_defines.svh"

module dcc_ctrl
  import dcc_pkg::*;
#(
  parameter logic [31:0] CAPACITY_RST = `DCC_CAPACITY_RST
) (
  input  wire logic           hclk,
  input  wire logic           hresetn,
  input  wire logic           hsel,
  input  wire logic [31:0]    haddr,
  input  wire logic [1:0]     htrans,
  input  wire logic           hwrite,
  input  wire logic [2:0]     hsize,
  input  wire logic [31:0]    hwdata,
  input  wire logic           hready,
  output logic                hreadyout,
  output logic                hresp,
  output logic [31:0]         hrdata,
  input  wire logic           motor_at_speed,
  input  wire logic           motor_stopped,
  output logic                motor_on,
  output logic                media_req,
  output dcc_media_cmd_t      media_cmd,
  input  wire logic           media_done,
  input  wire logic           media_ecc_err,
  input  wire logic           media_miscmp,
  output logic                cmd_busy
);

  // ========================================================================
  // State
  dcc_regs_t s_r;
  dcc_regs_t s_nxt;

  // ========================================================================
  // Register read view
  function automatic logic [31:0] dcc_read(input dcc_regs_t s, input logic [7:0] a,
                                           input logic spd);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      `DCC_OFF_CDB0:      v = s.cdb0;
      `DCC_OFF_CDB1:      v = s.cdb1;
      `DCC_OFF_CDB2:      v = {16'h0000, s.cdb2[15:0]};
      `DCC_OFF_STATUS: begin
        v[`DCC_ST_BUSY]     = s.busy;
        v[`DCC_ST_DONE]     = s.done;
        v[15:8]             = s.scsi_status;
        v[`DCC_ST_MOTOR_ON] = s.motor_on;
        v[`DCC_ST_AT_SPEED] = spd;
        v[`DCC_ST_POR_DONE] = s.por_done;
      end
      `DCC_OFF_SENSE:     v = {4'h0, s.sense_key, s.ascq, s.asc, 8'h00};
      `DCC_OFF_CONFIG:    v = {28'h000_0000, s.cfg_prio};
      `DCC_OFF_CAPACITY:  v = s.capacity;
      `DCC_OFF_RANGE_LBA: v = s.media_cmd.lba;
      `DCC_OFF_RANGE_CNT: v = s.media_cmd.cnt;
      default:            v = 32'h0000_0000;
    endcase
    return v;
  endfunction : dcc_read

  // ========================================================================
  // Next state
  always_comb begin
    logic        fin;
    logic        chk;
    logic [3:0]  key;
    logic [7:0]  asc;
    logic [7:0]  ascq;
    logic [7:0]  opc;
    logic [7:0]  b1;
    logic [7:0]  b4;
    logic [31:0] lba;
    logic [15:0] len;
    fin  = 1'b0;
    chk  = 1'b0;
    key  = `DCC_KEY_NONE;
    asc  = `DCC_ASCQ_ZERO;
    ascq = `DCC_ASCQ_ZERO;
    opc  = s_r.cdb0[7:0];
    b1   = s_r.cdb0[15:8];
    b4   = s_r.cdb1[7:0];
    lba  = {s_r.cdb0[23:16], s_r.cdb0[31:24], s_r.cdb1[7:0], s_r.cdb1[15:8]};
    len  = {s_r.cdb1[31:24], s_r.cdb2[7:0]};
    s_nxt           = s_r;
    s_nxt.media_req = 1'b0;
    s_nxt.hreadyout = 1'b1;
    s_nxt.hresp     = 1'b0;

    // The power-on period ends the first time the spindle reaches speed.
    if (motor_at_speed) begin
      s_nxt.por_done = 1'b1;
    end

    // Write data phase of the previous address phase.
    if (s_r.wr_pend) begin
      s_nxt.wr_pend = 1'b0;
      case (s_r.wr_addr)
        `DCC_OFF_CDB0: begin
          if (!s_r.busy) begin
            s_nxt.cdb0 = hwdata;
          end
        end
        `DCC_OFF_CDB1: begin
          if (!s_r.busy) begin
            s_nxt.cdb1 = hwdata;
          end
        end
        `DCC_OFF_CDB2: begin
          if (!s_r.busy) begin
            s_nxt.cdb2 = {16'h0000, hwdata[15:0]};
          end
        end
        `DCC_OFF_CMD: begin
          // A request while a command runs is dropped rather than queued.
          if (hwdata[`DCC_CMD_GO] && !s_r.busy) begin
            s_nxt.busy = 1'b1;
            s_nxt.fsm  = DCC_DECODE;
          end
        end
        `DCC_OFF_STATUS: begin
          if (hwdata[`DCC_ST_DONE]) begin
            s_nxt.done = 1'b0;
          end
        end
        `DCC_OFF_CONFIG:   s_nxt.cfg_prio = hwdata[3:0];
        `DCC_OFF_CAPACITY: s_nxt.capacity = hwdata;
        default: begin
        end
      endcase
    end

    // Address phase: reads are answered from the view at this edge.
    if (hsel && hready && htrans[1]) begin
      if (hwrite) begin
        s_nxt.wr_pend = 1'b1;
        s_nxt.wr_addr = haddr[7:0];
      end else begin
        s_nxt.hrdata = dcc_read(s_r, haddr[7:0], motor_at_speed);
      end
    end

    // Command sequencer.
    case (s_r.fsm)
      DCC_IDLE: begin
      end
      DCC_DECODE: begin
        if (!s_r.por_done && opc != `DCC_OPC_TUR && opc != `DCC_OPC_INQUIRY &&
            opc != `DCC_OPC_REQSENSE) begin
          fin  = 1'b1;
          chk  = 1'b1;
          key  = `DCC_KEY_NOT_READY;
          asc  = `DCC_ASC_NOT_READY;
          ascq = `DCC_ASCQ_BECOMING;
        end else begin
          case (opc)
            `DCC_OPC_TUR: begin
              // Only the spindle speed and the power-on flag are looked at; nothing is exercised.
              fin = 1'b1;
              if (!motor_at_speed) begin
                chk  = 1'b1;
                key  = `DCC_KEY_NOT_READY;
                asc  = `DCC_ASC_NOT_READY;
                ascq = s_r.por_done ? `DCC_ASCQ_NR_CAUSE : `DCC_ASCQ_BECOMING;
              end
            end
            `DCC_OPC_INQUIRY, `DCC_OPC_REQSENSE: begin
              // Sense stays in place so the initiator can read it back.
              fin = 1'b1;
            end
            `DCC_OPC_STARTSTOP: begin
              s_nxt.motor_on = b4[`DCC_CDB4_START];
              if (b1[`DCC_CDB1_IMMED]) begin
                fin = 1'b1;
              end else begin
                s_nxt.fsm = DCC_WAIT_MOTOR;
              end
            end
            `DCC_OPC_SYNCCACHE, `DCC_OPC_VERIFY: begin
              if (opc == `DCC_OPC_SYNCCACHE &&
                  (b1[`DCC_CDB1_SC_IMMED] || b1[`DCC_CDB1_RELADR])) begin
                fin = 1'b1;
                chk = 1'b1;
                key = `DCC_KEY_ILLEGAL;
                asc = `DCC_ASC_BAD_CDB;
              end else if (!motor_at_speed) begin
                fin  = 1'b1;
                chk  = 1'b1;
                key  = `DCC_KEY_NOT_READY;
                asc  = `DCC_ASC_NOT_READY;
                ascq = `DCC_ASCQ_NR_CAUSE;
              end else if (lba >= s_r.capacity) begin
                fin = 1'b1;
                chk = 1'b1;
                key = `DCC_KEY_ILLEGAL;
                asc = `DCC_ASC_LBA_RANGE;
              end else if (opc == `DCC_OPC_VERIFY && len == 16'h0000) begin
                fin = 1'b1;
              end else begin
                s_nxt.media_cmd.lba = lba;
                s_nxt.media_req     = 1'b1;
                s_nxt.fsm           = DCC_MEDIA_WAIT;
                if (opc == `DCC_OPC_SYNCCACHE) begin
                  s_nxt.media_cmd.op   = DCC_OP_FLUSH;
                  s_nxt.media_cmd.prio = s_r.cfg_prio;
                  if (len == 16'h0000) begin
                    s_nxt.media_cmd.cnt = s_r.capacity - lba;
                  end else begin
                    s_nxt.media_cmd.cnt = {16'h0000, len};
                  end
                end else begin
                  s_nxt.media_cmd.cnt = {16'h0000, len};
                  s_nxt.media_cmd.op  = b1[`DCC_CDB1_BYTCHK] ?
                                        DCC_OP_VERIFY_CMP : DCC_OP_VERIFY_ECC;
                  if (b1[`DCC_CDB1_DPO]) begin
                    s_nxt.media_cmd.prio = `DCC_PRIO_LOWEST;
                  end else begin
                    s_nxt.media_cmd.prio = s_r.cfg_prio;
                  end
                end
              end
            end
            default: begin
              fin = 1'b1;
              chk = 1'b1;
              key = `DCC_KEY_ILLEGAL;
              asc = `DCC_ASC_BAD_OPC;
            end
          endcase
        end
      end
      DCC_WAIT_MOTOR: begin
        if (s_r.motor_on ? motor_at_speed : motor_stopped) begin
          fin = 1'b1;
        end
      end
      DCC_MEDIA_WAIT: begin
        // Status is held back until the media engine reports the end.
        if (media_done) begin
          fin = 1'b1;
          case (s_r.media_cmd.op)
            DCC_OP_VERIFY_ECC: begin
              if (media_ecc_err) begin
                chk = 1'b1;
                key = `DCC_KEY_MEDIUM;
                asc = `DCC_ASC_READ_ERR;
              end
            end
            DCC_OP_VERIFY_CMP: begin
              if (media_miscmp) begin
                chk = 1'b1;
                key = `DCC_KEY_MISCMP;
                asc = `DCC_ASC_MISCMP;
              end
            end
            DCC_OP_FLUSH: begin
              if (media_ecc_err) begin
                chk = 1'b1;
                key = `DCC_KEY_MEDIUM;
                asc = `DCC_ASC_WRITE_ERR;
              end
            end
            default: begin
            end
          endcase
        end
      end
      default: s_nxt.fsm = DCC_IDLE;
    endcase

    // Completion comes after the software clear so that a finish wins.
    if (fin) begin
      s_nxt.fsm         = DCC_IDLE;
      s_nxt.busy        = 1'b0;
      s_nxt.done        = 1'b1;
      s_nxt.scsi_status = chk ? `DCC_STAT_CHECK : `DCC_STAT_GOOD;
      if (chk) begin
        s_nxt.sense_key = key;
        s_nxt.asc       = asc;
        s_nxt.ascq      = ascq;
      end
    end
  end

  // ========================================================================
  // Registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r                <= '0;
      s_r.hreadyout      <= 1'b1;
      s_r.cfg_prio       <= `DCC_PRIO_RESET;
      s_r.capacity       <= CAPACITY_RST;
      s_r.motor_on       <= 1'b1;
      s_r.fsm            <= DCC_IDLE;
      s_r.media_cmd.op   <= DCC_OP_FLUSH;
      s_r.scsi_status    <= `DCC_STAT_GOOD;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ========================================================================
  // Outputs
  assign hreadyout = s_r.hreadyout;
  assign hresp     = s_r.hresp;
  assign hrdata    = s_r.hrdata;
  assign motor_on  = s_r.motor_on;
  assign media_req = s_r.media_req;
  assign media_cmd = s_r.media_cmd;
  assign cmd_busy  = s_r.busy;

endmodule : dcc_ctrl

/* File: design/dcc_defines.svh */
// Offsets, field positions, codes and reset values of the disk unit command block.
`ifndef DCC_DEFINES_SVH
`define DCC_DEFINES_SVH

// ==========================================================================
// Register byte offsets
`define DCC_OFF_CDB0      8'h00
`define DCC_OFF_CDB1      8'h04
`define DCC_OFF_CDB2      8'h08
`define DCC_OFF_CMD       8'h0C
`define DCC_OFF_STATUS    8'h10
`define DCC_OFF_SENSE     8'h14
`define DCC_OFF_CONFIG    8'h18
`define DCC_OFF_CAPACITY  8'h1C
`define DCC_OFF_RANGE_LBA 8'h20
`define DCC_OFF_RANGE_CNT 8'h24

// ==========================================================================
// Field positions
`define DCC_CMD_GO        0
`define DCC_ST_BUSY       0
`define DCC_ST_DONE       1
`define DCC_ST_MOTOR_ON   16
`define DCC_ST_AT_SPEED   17
`define DCC_ST_POR_DONE   18
`define DCC_CDB1_IMMED    0
`define DCC_CDB1_RELADR   0
`define DCC_CDB1_SC_IMMED 1
`define DCC_CDB1_BYTCHK   1
`define DCC_CDB1_DPO      4
`define DCC_CDB4_START    0

// ==========================================================================
// Operation codes
`define DCC_OPC_TUR       8'h00
`define DCC_OPC_REQSENSE  8'h03
`define DCC_OPC_INQUIRY   8'h12
`define DCC_OPC_STARTSTOP 8'h1B
`define DCC_OPC_VERIFY    8'h2F
`define DCC_OPC_SYNCCACHE 8'h35

// ==========================================================================
// Status, sense keys and additional sense codes
`define DCC_STAT_GOOD     8'h00
`define DCC_STAT_CHECK    8'h02
`define DCC_KEY_NONE      4'h0
`define DCC_KEY_NOT_READY 4'h2
`define DCC_KEY_MEDIUM    4'h3
`define DCC_KEY_ILLEGAL   4'h5
`define DCC_KEY_MISCMP    4'hE
`define DCC_ASC_NOT_READY 8'h04
`define DCC_ASCQ_NR_CAUSE 8'h00
`define DCC_ASCQ_BECOMING 8'h01
`define DCC_ASC_BAD_OPC   8'h20
`define DCC_ASC_LBA_RANGE 8'h21
`define DCC_ASC_BAD_CDB   8'h24
`define DCC_ASC_WRITE_ERR 8'h0C
`define DCC_ASC_READ_ERR  8'h11
`define DCC_ASC_MISCMP    8'h1D
`define DCC_ASCQ_ZERO     8'h00

// ==========================================================================
// Priority levels and reset values
`define DCC_PRIO_LOWEST   4'h0
`define DCC_PRIO_RESET    4'h8
`define DCC_CAPACITY_RST  32'h0010_0000

`endif

/* File: design/dcc_pkg.sv */
// Types shared by the disk unit command block.
package dcc_pkg;

  // ========================================================================
  // Sequencer states and media operations
  typedef enum logic [2:0] {
    DCC_IDLE,
    DCC_DECODE,
    DCC_WAIT_MOTOR,
    DCC_MEDIA_WAIT
  } dcc_state_t;

  typedef enum logic [1:0] {
    DCC_OP_FLUSH,
    DCC_OP_VERIFY_ECC,
    DCC_OP_VERIFY_CMP
  } dcc_op_t;

  // ========================================================================
  // Media command carrier
  typedef struct packed {
    dcc_op_t     op;
    logic [31:0] lba;
    logic [31:0] cnt;
    logic [3:0]  prio;
  } dcc_media_cmd_t;

  // ========================================================================
  // Whole state of the block
  typedef struct packed {
    logic           hreadyout;
    logic           hresp;
    logic [31:0]    hrdata;
    logic           wr_pend;
    logic [7:0]     wr_addr;
    logic [31:0]    cdb0;
    logic [31:0]    cdb1;
    logic [31:0]    cdb2;
    logic [3:0]     cfg_prio;
    logic [31:0]    capacity;
    logic           busy;
    logic           done;
    logic [7:0]     scsi_status;
    logic [3:0]     sense_key;
    logic [7:0]     asc;
    logic [7:0]     ascq;
    logic           por_done;
    logic           motor_on;
    dcc_state_t     fsm;
    logic           media_req;
    dcc_media_cmd_t media_cmd;
  } dcc_regs_t;

endpackage : dcc_pkg

/* File: verif/dcc_ctrl_assertions.sv */
// Concurrent checks on the ports of the disk unit command block.
`timescale 1ns/1ps
module dcc_ctrl_assertions
  import dcc_pkg::*;
#(
  parameter logic [31:0] CAPACITY_RST = 32'h0010_0000
) (
  input wire logic           hclk,
  input wire logic           hresetn,
  input wire logic           hreadyout,
  input wire logic           hresp,
  input wire logic           motor_on,
  input wire logic           media_req,
  input wire dcc_media_cmd_t media_cmd,
  input wire logic           media_done,
  input wire logic           cmd_busy
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ==========================================================================
  // Helper state
  // A media operation stays pending from its request until the far side reports done.
  logic pend_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_r <= 1'b0;
    end else begin
      pend_r <= media_req | (pend_r & ~media_done);
    end
  end

  sequence s_req_pulse;
    media_req ##1 !media_req;
  endsequence

  // ==========================================================================
  // Properties
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response is not OKAY");
  a_ready_high: assert property (hreadyout == 1'b1)
    else $error("slave inserted a wait state");
  a_req_pulse: assert property (media_req |-> s_req_pulse)
    else $error("media request longer than one cycle");
  a_req_in_cmd: assert property (media_req |-> cmd_busy && $past(cmd_busy))
    else $error("media request outside a command");
  a_cmd_hold: assert property (pend_r && !media_req |-> $stable(media_cmd))
    else $error("media command changed while pending");
  a_flush_wait: assert property (pend_r && !media_done |=> cmd_busy)
    else $error("command ended before media done");
  a_motor_cause: assert property ($changed(motor_on) |-> $past(cmd_busy))
    else $error("motor command changed outside a command");
  a_cnt_nonzero: assert property (media_req |-> media_cmd.cnt != 32'h0)
    else $error("media request with zero count");
  a_flush_end: assert property (media_req |-> ({1'b0, media_cmd.lba} + media_cmd.cnt <=
    {1'b0, CAPACITY_RST}) && media_cmd.lba < CAPACITY_RST)
    else $error("media range leaves the unit");
  a_op_legal: assert property (media_req |-> media_cmd.op != 2'h3)
    else $error("undefined media operation");
endmodule : dcc_ctrl_assertions

bind dcc_ctrl dcc_ctrl_assertions #(.CAPACITY_RST(CAPACITY_RST)) i_chk (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .motor_on(motor_on), .media_req(media_req), .media_cmd(media_cmd),
  .media_done(media_done), .cmd_busy(cmd_busy));

/* File: verif/dcc_far_model.sv */
// Behavioural spindle and media model on the far side of the command block.
`timescale 1ns/1ps
module dcc_far_model #(
  parameter int SPIN = 200
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic motor_on,
  input  wire logic media_req,
  input  wire logic ecc_sel,
  input  wire logic cmp_sel,
  output logic      motor_at_speed,
  output logic      motor_stopped,
  output logic      media_done,
  output logic      media_ecc_err,
  output logic      media_miscmp
);
  int  spd;
  int  wait_c;
  logic tog;

  // ==========================================================================
  // Spindle ramps one step a cycle, media answers a fixed time after a request.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      spd <= 0;
      wait_c <= 0;
      media_done <= 1'b0;
      tog <= 1'b0;
    end else begin
      tog <= ~tog;
      if (motor_on && spd < SPIN) spd <= spd + 1;
      else if (!motor_on && spd > 0) spd <= spd - 1;
      media_done <= (wait_c == 1);
      if (media_req) wait_c <= 9;
      else if (wait_c != 0) wait_c <= wait_c - 1;
    end
  end
  assign motor_at_speed = (spd == SPIN);
  assign motor_stopped  = (spd == 0);
  // Error flags toggle outside done so a design sampling them early is caught.
  assign media_ecc_err  = media_done ? ecc_sel : tog;
  assign media_miscmp   = media_done ? cmp_sel : ~tog;
endmodule : dcc_far_model

/* File: verif/disk_unit_control_commands_bench.sv */
// Self-checking bench for the disk unit command block.
`timescale 1ns/1ps
`include "dcc_defines.svh"
module disk_unit_control_commands_bench
  import dcc_pkg::*;
;
  localparam logic [31:0] CAP = 32'h0000_0100;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic ecc_sel = 1'b0, cmp_sel = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, seed = 32'h21C1;
  logic hreadyout, hresp, motor_on, media_req, cmd_busy;
  logic at_spd, stopped, m_done, m_ecc, m_cmp;
  dcc_media_cmd_t media_cmd, last_cmd;
  int failures = 0, checks = 0, cyc = 0, nreq = 0;
  logic [7:0] ops [6] = '{`DCC_OPC_TUR, `DCC_OPC_INQUIRY, `DCC_OPC_REQSENSE,
                          `DCC_OPC_STARTSTOP, `DCC_OPC_VERIFY, `DCC_OPC_SYNCCACHE};
  logic [1:0] steps [5] = '{2'h0, 2'h3, 2'h2, 2'h1, 2'h2};

  always #12.5 hclk = ~hclk;

  dcc_ctrl #(.CAPACITY_RST(CAP)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .motor_at_speed(at_spd), .motor_stopped(stopped), .motor_on(motor_on),
    .media_req(media_req), .media_cmd(media_cmd), .media_done(m_done),
    .media_ecc_err(m_ecc), .media_miscmp(m_cmp), .cmd_busy(cmd_busy));
  dcc_far_model #(.SPIN(200)) i_far (.hclk(hclk), .hresetn(hresetn), .motor_on(motor_on),
    .media_req(media_req), .ecc_sel(ecc_sel), .cmp_sel(cmp_sel), .motor_at_speed(at_spd),
    .motor_stopped(stopped), .media_done(m_done), .media_ecc_err(m_ecc),
    .media_miscmp(m_cmp));

  // ==========================================================================
  // Helpers
  task give_verdict();
    if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (media_req === 1'b1) begin
      nreq <= nreq + 1;
      last_cmd <= media_cmd;
    end
    if (cyc == 20000) begin
      failures = failures + 1;
      give_verdict();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [31:0] obs(input logic [31:0] st, sn);
    return {4'h0, st[15:8], sn[27:24], sn[15:8], sn[23:16]};
  endfunction : obs

  function automatic logic [31:0] sw(input logic [7:0] s, input logic [3:0] k,
                                     input logic [7:0] a, q);
    return {4'h0, s, k, a, q};
  endfunction : sw

  task chk(input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Single word transfer: address phase, then data phase, each held until hready.
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : ahb

  task run(input logic [7:0] opc, b1, input logic [31:0] lba, input logic [15:0] len,
           output logic [31:0] st, sn);
    logic [31:0] t;
    ahb(1'b1, `DCC_OFF_CDB0, {lba[23:16], lba[31:24], b1, opc}, t);
    ahb(1'b1, `DCC_OFF_CDB1, {len[15:8], 8'h00, lba[7:0], lba[15:8]}, t);
    ahb(1'b1, `DCC_OFF_CDB2, {24'h0, len[7:0]}, t);
    ahb(1'b1, `DCC_OFF_STATUS, 32'h2, t);
    ahb(1'b1, `DCC_OFF_CMD, 32'h1, t);
    st = 32'h0;
    for (int i = 0; i < 600 && st[1] !== 1'b1; i++) ahb(1'b0, `DCC_OFF_STATUS, 32'h0, st);
    ahb(1'b0, `DCC_OFF_SENSE, 32'h0, sn);
  endtask : run

  // ==========================================================================
  // Main sequence
  initial begin
    logic [31:0] st, sn, t, lba, p, ex;
    logic [15:0] len;
    int n0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    chk(32'(motor_on), 32'h1);
    ahb(1'b0, `DCC_OFF_CONFIG, 32'h0, t);
    chk(t, 32'(`DCC_PRIO_RESET));
    ahb(1'b0, `DCC_OFF_CAPACITY, 32'h0, t);
    chk(t, CAP);
    ahb(1'b0, 8'h3C, 32'h0, t);
    chk(t, 32'h0);
    for (int i = 0; i < 6; i++) begin
      run(ops[i], 8'h0, 32'h0, 16'h1, st, sn);
      ex = (i == 1 || i == 2) ? `DCC_STAT_GOOD : `DCC_STAT_CHECK;
      chk(obs(st, sn), sw(ex[7:0], `DCC_KEY_NOT_READY, `DCC_ASC_NOT_READY,
          `DCC_ASCQ_BECOMING));
    end
    for (int i = 0; i < 300 && t[18] !== 1'b1; i++) ahb(1'b0, `DCC_OFF_STATUS, 32'h0, t);
    n0 = nreq;
    run(`DCC_OPC_TUR, 8'h0, 32'h0, 16'h0, st, sn);
    chk(32'(st[15:8]), 32'(`DCC_STAT_GOOD));
    chk(32'(nreq), 32'(n0));
    for (int k = 0; k < 5; k++) begin
      lba = {16'h0, 7'h0, steps[k][1], 8'h0};
      run(`DCC_OPC_STARTSTOP, {7'h0, steps[k][0]}, lba, 16'h0, st, sn);
      chk(32'(st[15:8]), 32'(`DCC_STAT_GOOD));
      chk(32'(motor_on), 32'(steps[k][1]));
      if (!steps[k][0]) chk(32'(steps[k][1] ? at_spd : stopped), 32'h1);
      else if (steps[k][1]) chk(32'(at_spd), 32'h0);
      if (k == 0) begin
        run(`DCC_OPC_TUR, 8'h0, 32'h0, 16'h0, st, sn);
        chk(obs(st, sn), sw(`DCC_STAT_CHECK, `DCC_KEY_NOT_READY, `DCC_ASC_NOT_READY,
            `DCC_ASCQ_NR_CAUSE));
      end
      for (int j = 0; k == 1 && j < 100 && st[15:8] !== `DCC_STAT_GOOD; j++) begin
        run(`DCC_OPC_TUR, 8'h0, 32'h0, 16'h0, st, sn);
      end
    end
    for (int j = 1; j < 3; j++) begin
      run(`DCC_OPC_SYNCCACHE, 8'(j), 32'h0, 16'h1, st, sn);
      chk(obs(st, sn), sw(`DCC_STAT_CHECK, `DCC_KEY_ILLEGAL, `DCC_ASC_BAD_CDB,
          `DCC_ASCQ_ZERO));
    end
    for (int j = 0; j < 4; j++) begin
      lba = (j == 0) ? CAP - 1 : rnd() % CAP;
      len = (j == 0) ? 16'h0 : 16'(rnd() % (CAP - lba));
      ecc_sel <= (j == 3);
      run(`DCC_OPC_SYNCCACHE, 8'h0, lba, len, st, sn);
      chk(last_cmd.lba, lba);
      chk(last_cmd.cnt, (len == 16'h0) ? CAP - lba : 32'(len));
      ex = sw(`DCC_STAT_CHECK, `DCC_KEY_MEDIUM, `DCC_ASC_WRITE_ERR, `DCC_ASCQ_ZERO);
      if (j == 3) chk(obs(st, sn), ex);
      else chk(32'(st[15:8]), 32'(`DCC_STAT_GOOD));
    end
    for (int j = 0; j < 8; j++) begin
      p = rnd() & 32'hF;
      ahb(1'b1, `DCC_OFF_CONFIG, p, t);
      lba = rnd() % CAP;
      len = 16'(1 + rnd() % (CAP - lba));
      ecc_sel <= j[2] & ~j[0];
      cmp_sel <= j[2] & j[0];
      run(`DCC_OPC_VERIFY, {3'h0, j[1], 2'h0, j[0], 1'b0}, lba, len, st, sn);
      ex = j[0] ? 32'(DCC_OP_VERIFY_CMP) : 32'(DCC_OP_VERIFY_ECC);
      chk(32'(last_cmd.op), ex);
      chk(32'(last_cmd.prio), j[1] ? 32'(`DCC_PRIO_LOWEST) : p);
      ex = j[0] ? sw(`DCC_STAT_CHECK, `DCC_KEY_MISCMP, `DCC_ASC_MISCMP, `DCC_ASCQ_ZERO)
                : sw(`DCC_STAT_CHECK, `DCC_KEY_MEDIUM, `DCC_ASC_READ_ERR, `DCC_ASCQ_ZERO);
      if (j[2]) chk(obs(st, sn), ex);
      else chk(32'(st[15:8]), 32'(`DCC_STAT_GOOD));
    end
    n0 = nreq;
    run(`DCC_OPC_VERIFY, 8'h0, 32'h5, 16'h0, st, sn);
    chk(32'(st[15:8]), 32'(`DCC_STAT_GOOD));
    chk(32'(nreq), 32'(n0));
    give_verdict();
  end
endmodule : disk_unit_control_commands_bench
